// ---- iwd_pkg.sv ----
package iwd_pkg;

   localparam logic [15:0] IWD_PORT_ADDR  = 16'h0443;
   localparam logic [7:0]  IWD_CODE_MIN   = 8'h01;
   localparam logic [7:0]  IWD_CODE_MAX   = 8'h3E;
   localparam logic [7:0]  IWD_CODE_RST   = 8'h00;

   localparam int          IWD_CLK_HZ     = 50_000_000;
   localparam int          IWD_TICK_MS    = 1000;
   localparam int          IWD_TICK_CYC   = (IWD_CLK_HZ / 1000) * IWD_TICK_MS;
   localparam int          IWD_PRE_W      = 26;

   localparam int          IWD_RST_NS     = 1000;
   localparam int          IWD_RST_CYC    = (IWD_RST_NS * (IWD_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [7:0]  IWD_RST_LEN    = 8'(IWD_RST_CYC);

   typedef struct packed {
      logic        aen;
      logic        ior_n;
      logic        iow_n;
      logic [15:0] addr;
      logic [7:0]  data;
   } iwd_isa_t;

   typedef enum logic [2:0] {
      IWD_IDLE  = 3'b001,
      IWD_ARMED = 3'b010,
      IWD_FIRED = 3'b100
   } iwd_state_t;

endpackage

// ---- iwd_top.sv ----
`timescale 1ns/1ps

// Notes on behaviour
// - expiry resets cpu or raises interrupt
// - write of a code 01h..3Eh to port 443h loads interval, restarts
// - codes 01h..3Eh give 1..62 seconds
// - any port read disables the watchdog
module iwd_top
   import iwd_pkg::*;
#(
   parameter int TICK_CYCLES = IWD_TICK_CYC
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       aen,
   input  wire logic       ior_n,
   input  wire logic       iow_n,
   input  wire logic [15:0] sa,
   input  wire logic [7:0] sd_in,
   output      logic [7:0] sd_out,
   output      logic       sd_oe,
   input  wire logic       irq_mode,
   output      logic       cpu_reset,
   output      logic       wdt_irq,
   output      logic       wdt_armed
);

   iwd_isa_t   pin_raw;
   iwd_isa_t   sync1_q;
   iwd_isa_t   sync2_q;
   logic       ior_d1_q;
   logic       iow_d1_q;
   logic       mode1_q;
   logic       mode2_q;
   logic       hit;
   logic       rd_start;
   logic       wr_start;
   logic       valid_code;
   logic       load;
   logic [7:0] code_q;
   logic [7:0] secs_q;
   logic [IWD_PRE_W-1:0] pre_q;
   logic       tick;
   logic       expire;
   logic [7:0] rst_cnt_q;
   iwd_state_t state_q;

   function automatic logic in_range(input logic [7:0] c);
      in_range = (c >= IWD_CODE_MIN) && (c <= IWD_CODE_MAX);
   endfunction

   // strobes are active low; a start is the high-to-low step seen after sync
   function automatic logic strobe_fell(input logic prev_n, input logic now_n);
      strobe_fell = prev_n && !now_n;
   endfunction

   assign pin_raw = '{aen: aen, ior_n: ior_n, iow_n: iow_n, addr: sa, data: sd_in};

   // pins are asynchronous to mclk, so everything gets two stages
   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1_q <= '{aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1, addr: '0, data: '0};
         sync2_q <= '{aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1, addr: '0, data: '0};
         mode1_q <= 1'b0;
         mode2_q <= 1'b0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         mode1_q <= irq_mode;
         mode2_q <= mode1_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ior_d1_q <= 1'b1;
         iow_d1_q <= 1'b1;
      end else begin
         ior_d1_q <= sync2_q.ior_n;
         iow_d1_q <= sync2_q.iow_n;
      end
   end

   // aen high means a dma cycle, not a cpu port access
   assign hit      = !sync2_q.aen && (sync2_q.addr == IWD_PORT_ADDR);
   assign rd_start = hit && strobe_fell(ior_d1_q, sync2_q.ior_n);
   // data is taken on the strobe edge seen after sync; isa holds it well past that
   assign wr_start = hit && strobe_fell(iow_d1_q, sync2_q.iow_n);
   assign valid_code = in_range(sync2_q.data);
   // a code outside the table changes nothing but the interrupt
   assign load     = wr_start && valid_code;

   always_ff @(posedge mclk) begin
      if (rst) begin
         code_q <= IWD_CODE_RST;
      end else if (load) begin
         code_q <= sync2_q.data;
      end
   end

   // read-back shows the interval code; driven only while the read strobe stands
   always_ff @(posedge mclk) begin
      if (rst) begin
         sd_oe <= 1'b0;
      end else if (rd_start) begin
         sd_oe <= 1'b1;
      end else if (sync2_q.ior_n) begin
         sd_oe <= 1'b0;
      end
   end

   // data is held between reads, so the bus never sees it change while undriven
   always_ff @(posedge mclk) begin
      if (rst) begin
         sd_out <= IWD_CODE_RST;
      end else if (rd_start) begin
         sd_out <= code_q;
      end
   end

   // prescaler restarts on every load so the first second is a full one
   always_ff @(posedge mclk) begin
      if (rst || state_q != IWD_ARMED || load) begin
         pre_q <= '0;
      end else if (tick) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // prescaler is held at zero outside the armed state, so no stray tick
   assign tick   = (state_q == IWD_ARMED) &&
                   (pre_q == IWD_PRE_W'(TICK_CYCLES - 1));
   // a refresh or a read in the expiry cycle wins over the expiry
   assign expire = tick && (secs_q == 8'h01) && !load && !rd_start;

   always_ff @(posedge mclk) begin
      if (rst) begin
         secs_q <= 8'h00;
      end else if (load) begin
         secs_q <= sync2_q.data;
      end else if (tick && secs_q != 8'h00) begin
         secs_q <= secs_q - 8'h01;
      end
   end

   // a read wins in the armed and fired states, even over a write that re-arms a fired timer; in idle a write still arms
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= IWD_IDLE;
      end else begin
         case (state_q)
            IWD_IDLE: begin
               if (load) begin
                  state_q <= IWD_ARMED;
               end
            end
            IWD_ARMED: begin
               if (rd_start) begin
                  state_q <= IWD_IDLE;
               end else if (expire) begin
                  state_q <= IWD_FIRED;
               end
            end
            IWD_FIRED: begin
               if (rd_start) begin
                  state_q <= IWD_IDLE;
               end else if (load) begin
                  state_q <= IWD_ARMED;
               end
            end
            default: begin
               state_q <= IWD_IDLE;
            end
         endcase
      end
   end

   // reset is a fixed pulse; the interrupt stays up until software touches the port
   always_ff @(posedge mclk) begin
      if (rst) begin
         rst_cnt_q <= 8'h00;
      end else if (expire && !mode2_q) begin
         rst_cnt_q <= IWD_RST_LEN;
      end else if (rst_cnt_q != 8'h00) begin
         rst_cnt_q <= rst_cnt_q - 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cpu_reset <= 1'b0;
      end else if (expire && !mode2_q) begin
         cpu_reset <= 1'b1;
      end else if (rst_cnt_q == 8'h01) begin
         cpu_reset <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wdt_irq <= 1'b0;
      end else if (expire && mode2_q) begin
         wdt_irq <= 1'b1;
      end else if (rd_start || wr_start) begin
         wdt_irq <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wdt_armed <= 1'b0;
      end else begin
         wdt_armed <= (state_q == IWD_ARMED);
      end
   end

endmodule

// ---- iwd_top_chk.sv ----
`timescale 1ns/1ps
module iwd_top_chk #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        aen,
   input wire logic        ior_n,
   input wire logic        iow_n,
   input wire logic [15:0] sa,
   input wire logic [7:0]  sd_in,
   input wire logic        sd_oe,
   input wire logic        irq_mode,
   input wire logic        cpu_reset,
   input wire logic        wdt_irq,
   input wire logic        wdt_armed
);
   logic hit;
   assign hit = !aen && sa == 16'h0443;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   chk_rst_len: assert property ($rose(cpu_reset) |-> ##49 cpu_reset ##1 !cpu_reset)
      else $error("reset pulse length");
   chk_irq_sel: assert property ($rose(wdt_irq) |-> irq_mode)
      else $error("irq in reset mode");
   chk_exp_off: assert property ($rose(cpu_reset) |-> ##[0:2] !wdt_armed)
      else $error("armed after expiry");
   chk_wr_arm: assert property (
      $fell(iow_n) && hit && sd_in inside {[8'h01:8'h3E]} |-> ##[2:6] wdt_armed)
      else $error("write did not arm");
   chk_bad_code: assert property (
      $fell(iow_n) && hit && (sd_in == 8'h00 || sd_in > 8'h3E) && !wdt_armed
      |-> ##6 !wdt_armed)
      else $error("bad code armed");
   chk_dma_skip: assert property (
      $fell(iow_n) && aen && !wdt_armed |-> ##6 !wdt_armed)
      else $error("dma cycle armed");
   chk_rd_off: assert property ($fell(ior_n) && hit |-> ##[2:6] !wdt_armed)
      else $error("read left armed");
   chk_rd_drive: assert property ($fell(ior_n) && hit |-> ##[2:6] sd_oe)
      else $error("read not driven");
   chk_oe_idle: assert property (ior_n [*6] |-> !sd_oe)
      else $error("bus driven idle");
   cover property ($rose(wdt_armed));
   cover property ($rose(cpu_reset));
   cover property ($rose(wdt_irq));
   cover property ($fell(ior_n) && hit);
endmodule

// ---- iwd_host.sv ----
`timescale 1ns/1ps
module iwd_host (
   input  wire logic        mclk,
   input  wire logic [7:0]  sd_out,
   output      logic        aen,
   output      logic        ior_n,
   output      logic        iow_n,
   output      logic [15:0] sa,
   output      logic [7:0]  sd_in
);
   initial begin
      aen = 1'b0;
      ior_n = 1'b1;
      iow_n = 1'b1;
      sa = 16'h0000;
      sd_in = 8'h00;
   end
   // strobes 4 cycles each way, longer than the 2-flop sync needs
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge mclk);
      sa <= a;
      sd_in <= d;
      iow_n <= !w;
      ior_n <= w;
      repeat (4) @(posedge mclk);
      q = sd_out;
      iow_n <= 1'b1;
      ior_n <= 1'b1;
      repeat (4) @(posedge mclk);
      sd_in <= ~d;
   endtask
   // dma cycle: aen high hides the access from every port decoder
   task automatic dma(input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge mclk);
      aen <= 1'b1;
      acc(1'b1, a, d, q);
      aen <= 1'b0;
   endtask
endmodule

// ---- iwd_top_tb.sv ----
`timescale 1ns/1ps
module iwd_top_tb;
   import iwd_pkg::*;
   localparam int T = 10;
   localparam logic [7:0] CD[6] = '{8'h01, 8'h02, 8'h3E, 8'h00, 8'h3F, 8'hFF};
   // seconds each code should give; 0 marks a refused code
   localparam int ROW_SECS[6] = '{1, 2, 62, 0, 0, 0};
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic irq_mode = 1'b0;
   logic aen, ior_n, iow_n, sd_oe, cpu_reset, wdt_irq, wdt_armed;
   logic [15:0] sa;
   logic [7:0] sd_in, sd_out, q;
   int errors = 0;
   int n_checks = 0;
   int got;
   always #10 mclk = ~mclk;
   iwd_top #(.TICK_CYCLES(T)) iwd_top_inst (
      .mclk      (mclk),
      .rst       (rst),
      .aen       (aen),
      .ior_n     (ior_n),
      .iow_n     (iow_n),
      .sa        (sa),
      .sd_in     (sd_in),
      .sd_out    (sd_out),
      .sd_oe     (sd_oe),
      .irq_mode  (irq_mode),
      .cpu_reset (cpu_reset),
      .wdt_irq   (wdt_irq),
      .wdt_armed (wdt_armed)
   );
   iwd_host iwd_host_inst (
      .mclk   (mclk),
      .sd_out (sd_out),
      .aen    (aen),
      .ior_n  (ior_n),
      .iow_n  (iow_n),
      .sa     (sa),
      .sd_in  (sd_in)
   );
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   // expiry seen 2..6 cycles late: sync and registered output
   task automatic chk_t(input string s, input int e, input int g);
      n_checks++;
      if (e == 0 ? g != 0 : (g < e + 2 || g > e + 6)) begin
         errors++;
         $display("[ERR] %s exp %0d got %0d", s, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      iwd_host_inst.acc(1'b1, a, d, q);
   endtask
   task automatic meas(input logic irq);
      got = 8;
      while (got < 700 && (irq ? wdt_irq : cpu_reset) !== 1'b1) begin
         @(negedge mclk);
         got++;
      end
      if (got >= 700) got = 0;
      repeat (60) @(posedge mclk);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #300000;
      errors++;
      stop_test;
   end
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      iwd_host_inst.acc(1'b0, IWD_PORT_ADDR, 8'h00, q);
      chk("rd0", 8'h00, q);
      chk("idle", 8'h00, {4'h0, sd_oe, cpu_reset, wdt_irq, wdt_armed});
      foreach (CD[i]) begin
         wr(IWD_PORT_ADDR, CD[i]);
         meas(1'b0);
         chk_t("row", ROW_SECS[i] * T, got);
         $display("row %0d", i);
      end
      wr(IWD_PORT_ADDR, 8'h02);
      repeat (8) @(posedge mclk);
      wr(IWD_PORT_ADDR, 8'h02);
      meas(1'b0);
      chk_t("refresh", 2 * T, got);
      wr(IWD_PORT_ADDR, 8'h03);
      iwd_host_inst.acc(1'b0, IWD_PORT_ADDR, 8'h00, q);
      chk("rdval", 8'h03, q);
      meas(1'b0);
      chk_t("rdoff", 0, got);
      wr(16'h0442, 8'h01);
      meas(1'b0);
      chk_t("addr", 0, got);
      iwd_host_inst.dma(IWD_PORT_ADDR, 8'h01, q);
      meas(1'b0);
      chk_t("dma", 0, got);
      wr(IWD_PORT_ADDR, 8'h02);
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      chk("rstmid", 8'h00, {4'h0, sd_oe, cpu_reset, wdt_irq, wdt_armed});
      meas(1'b0);
      chk_t("rstoff", 0, got);
      $display("hand");
      irq_mode <= 1'b1;
      wr(IWD_PORT_ADDR, 8'h01);
      meas(1'b1);
      chk_t("irq", T, got);
      chk("irqlvl", 8'h01, {7'h00, wdt_irq});
      iwd_host_inst.acc(1'b0, IWD_PORT_ADDR, 8'h00, q);
      chk("irqclr", 8'h00, {7'h00, wdt_irq});
      $display("irq");
      stop_test;
   end
endmodule
bind iwd_top iwd_top_chk #(.TICK_CYCLES(TICK_CYCLES)) iwd_top_chk_inst (
   .mclk      (mclk),
   .rst       (rst),
   .aen       (aen),
   .ior_n     (ior_n),
   .iow_n     (iow_n),
   .sa        (sa),
   .sd_in     (sd_in),
   .sd_oe     (sd_oe),
   .irq_mode  (irq_mode),
   .cpu_reset (cpu_reset),
   .wdt_irq   (wdt_irq),
   .wdt_armed (wdt_armed)
);
